// ---- hdl/csr_pkg.sv ----
// Package: constants, register map and carrier types of the secondary
// readout sequencer. Assumes a 50 MHz system clock.
package csr_pkg;

	// ***********************************************************
	// Timing
	// ***********************************************************
	localparam int CLK_MHZ = 50;
	localparam int SER_PER0_NS = 800;
	localparam int SER_PER1_NS = 400;
	localparam int SER_PER2_NS = 100;
	localparam int SER_PER3_NS = 50;
	localparam int SER_PER0_CYC = (SER_PER0_NS * CLK_MHZ + 999) / 1000;
	localparam int SER_PER1_CYC = (SER_PER1_NS * CLK_MHZ + 999) / 1000;
	localparam int SER_PER2_CYC = (SER_PER2_NS * CLK_MHZ + 999) / 1000;
	localparam int SER_PER3_CYC = (SER_PER3_NS * CLK_MHZ + 999) / 1000;
	localparam int SAMPLE_UNIT_NS = 100;
	localparam int SAMPLE_UNIT_CYC = (SAMPLE_UNIT_NS * CLK_MHZ + 999) / 1000;
	localparam int ERASE_STEP_MS = 10;
	localparam int ERASE_STEP_CYC = ERASE_STEP_MS * CLK_MHZ * 1000;
	localparam logic [7:0] AUTO_CAP_SAMPLE_MAX = 8'h27;
	localparam logic [15:0] IDLE_ENDLESS = 16'hFFFF;

	// ***********************************************************
	// Register byte offsets
	// ***********************************************************
	localparam logic [7:0] OFS_MPP = 8'h00;
	localparam logic [7:0] OFS_OV_ROWS_LO = 8'h01;
	localparam logic [7:0] OFS_OV_ROWS_HI = 8'h02;
	localparam logic [7:0] OFS_OV_COLS_LO = 8'h03;
	localparam logic [7:0] OFS_OV_COLS_HI = 8'h04;
	localparam logic [7:0] OFS_ERASE_LO = 8'h05;
	localparam logic [7:0] OFS_ERASE_HI = 8'h06;
	localparam logic [7:0] OFS_IDLE_LO = 8'h07;
	localparam logic [7:0] OFS_IDLE_HI = 8'h08;
	localparam logic [7:0] OFS_SER_CODE = 8'h10;
	localparam logic [7:0] OFS_PRE1_LO = 8'h11;
	localparam logic [7:0] OFS_PRE1_HI = 8'h12;
	localparam logic [7:0] OFS_PRE2_LO = 8'h13;
	localparam logic [7:0] OFS_PRE2_HI = 8'h14;
	localparam logic [7:0] OFS_SKIP_FLAG = 8'h18;
	localparam logic [7:0] OFS_SKIP_BIN = 8'h19;
	localparam logic [7:0] OFS_SKIP_SAMPLE = 8'h1A;
	localparam logic [7:0] OFS_FLUSH_FLAG = 8'h1B;
	localparam logic [7:0] OFS_FLUSH_BIN = 8'h1C;
	localparam logic [7:0] OFS_FLUSH_SAMPLE = 8'h1D;
	localparam logic [7:0] OFS_SAMPLE_CAP = 8'h1E;
	localparam logic [7:0] OFS_SER_CAP = 8'h1F;
	localparam logic [7:0] OFS_STATUS = 8'h20;

	// ***********************************************************
	// Reset values
	// ***********************************************************
	localparam logic [15:0] RST_PRE1 = 16'h0004;
	localparam logic [15:0] RST_PRE2 = 16'h0004;
	localparam logic [1:0] RST_SER_CODE = 2'h0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;

	// ***********************************************************
	// Types
	// ***********************************************************
	typedef enum logic [3:0] {
		ST_IDLE, ST_ERASE, ST_EXPOSE, ST_FROW, ST_FSER, ST_ROWS_INIT,
		ST_ROWSTART, ST_SKIP1, ST_PRE1, ST_PIX, ST_SKIP2, ST_PRE2,
		ST_OVCOL, ST_ROW_END
	} csr_phase_t;

	typedef enum logic [1:0] {
		FK_PSKIP1, FK_PSKIP2, FK_IDLE
	} csr_fkind_t;

	// Geometry and primary settings supplied by the window block
	typedef struct packed {
		logic [15:0] win_rows;
		logic [15:0] win_cols;
		logic [15:0] col_skip;
		logic [15:0] row_len;
		logic [15:0] par_skip1;
		logic [15:0] par_skip2;
		logic [7:0] bin_exp;
		logic [7:0] sample;
	} csr_window_t;

	// Drive towards the clock and analog stages
	typedef struct packed {
		logic clamp_levels;
		logic special_state;
		logic clocks_frozen;
		logic par_tick;
		logic ser_tick;
		logic pix_valid;
		logic [7:0] bin_exp;
		logic [7:0] sample;
		logic sample_cap_large;
		logic ser_cap_on;
		logic busy;
	} csr_drive_t;

	typedef struct packed {
		logic mpp;
		logic [15:0] ov_rows;
		logic [15:0] ov_cols;
		logic [15:0] erase_time;
		logic [15:0] idle_rows;
		logic [1:0] ser_code;
		logic [15:0] pre1;
		logic [15:0] pre2;
		logic [7:0] skip_flag;
		logic [7:0] skip_bin;
		logic [7:0] skip_sample;
		logic [7:0] flush_flag;
		logic [7:0] flush_bin;
		logic [7:0] flush_sample;
		logic [7:0] sample_cap;
		logic [7:0] ser_cap;
	} csr_params_t;

endpackage

// ---- hdl/csr_sequencer.sv ----
// Secondary readout sequencer: parameter registers and readout walk.
// Assumes the window block and the command decoder share clock_i.
`timescale 1ns/10ps
`default_nettype none

module csr_sequencer #(
	parameter int ERASE_STEP_CYC = csr_pkg::ERASE_STEP_CYC
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire csr_pkg::csr_window_t window_i,
	input wire logic expose_start_i,
	input wire logic readout_start_i,
	output csr_pkg::csr_drive_t drive_o
);

	// ***********************************************************
	// State
	// ***********************************************************
	typedef struct packed {
		csr_pkg::csr_params_t prm;
		logic [7:0] lo_stage;
		logic [7:0] rdata;
		csr_pkg::csr_phase_t phase;
		csr_pkg::csr_fkind_t fkind;
		logic row_ov;
		logic [15:0] rows;
		logic [15:0] pix;
		logic [15:0] tcnt;
		logic [31:0] ecnt;
		csr_pkg::csr_drive_t drv;
	} csr_state_t;

	csr_state_t s_r;
	csr_state_t s_nxt;

	// ***********************************************************
	// Helpers
	// ***********************************************************
	function automatic logic [15:0] ser_cycles(input logic [1:0] code);
		logic [15:0] c;
		c = 16'(csr_pkg::SER_PER0_CYC);
		case (code)
			2'h1: c = 16'(csr_pkg::SER_PER1_CYC);
			2'h2: c = 16'(csr_pkg::SER_PER2_CYC);
			2'h3: c = 16'(csr_pkg::SER_PER3_CYC);
			default: c = 16'(csr_pkg::SER_PER0_CYC);
		endcase
		return c;
	endfunction

	// Pixels per transfer; huge exponents saturate
	function automatic logic [15:0] bin_step(input logic [7:0] e);
		logic [15:0] st;
		st = (e >= 8'h10) ? 16'hFFFF : (16'h0001 << e[3:0]);
		return st;
	endfunction

	// ***********************************************************
	// Next state
	// ***********************************************************
	logic serial;
	logic skip_ph;
	logic flush_ph;
	logic px_count;
	logic done;
	logic leave_idle;
	logic [7:0] bin_cur;
	logic [7:0] smp_cur;
	logic [15:0] step;
	logic [15:0] period;
	logic [31:0] pre1_avail;
	logic [15:0] pre1_eff;
	logic [31:0] rem;
	logic [31:0] pre2_px;

	always_comb begin
		s_nxt = s_r;
		serial = 1'b0;
		done = 1'b0;
		s_nxt.drv.par_tick = 1'b0;
		s_nxt.drv.ser_tick = 1'b0;
		s_nxt.drv.pix_valid = 1'b0;

		// Register writes; a 16-bit count commits on its high byte
		if (wr_i) begin
			if (addr_i == csr_pkg::OFS_MPP) begin
				s_nxt.prm.mpp = (wdata_i != 8'h00);
			end else if (addr_i == csr_pkg::OFS_OV_ROWS_HI) begin
				s_nxt.prm.ov_rows = {wdata_i, s_r.lo_stage};
			end else if (addr_i == csr_pkg::OFS_OV_COLS_HI) begin
				s_nxt.prm.ov_cols = {wdata_i, s_r.lo_stage};
			end else if (addr_i == csr_pkg::OFS_ERASE_HI) begin
				s_nxt.prm.erase_time = {wdata_i, s_r.lo_stage};
			end else if (addr_i == csr_pkg::OFS_IDLE_HI) begin
				s_nxt.prm.idle_rows = {wdata_i, s_r.lo_stage};
			end else if (addr_i == csr_pkg::OFS_SER_CODE) begin
				s_nxt.prm.ser_code = wdata_i[1:0];
			end else if (addr_i == csr_pkg::OFS_PRE1_HI) begin
				s_nxt.prm.pre1 = {wdata_i, s_r.lo_stage};
			end else if (addr_i == csr_pkg::OFS_PRE2_HI) begin
				s_nxt.prm.pre2 = {wdata_i, s_r.lo_stage};
			end else if (addr_i == csr_pkg::OFS_SKIP_FLAG) begin
				s_nxt.prm.skip_flag = wdata_i;
			end else if (addr_i == csr_pkg::OFS_SKIP_BIN) begin
				s_nxt.prm.skip_bin = wdata_i;
			end else if (addr_i == csr_pkg::OFS_SKIP_SAMPLE) begin
				s_nxt.prm.skip_sample = wdata_i;
			end else if (addr_i == csr_pkg::OFS_FLUSH_FLAG) begin
				s_nxt.prm.flush_flag = wdata_i;
			end else if (addr_i == csr_pkg::OFS_FLUSH_BIN) begin
				s_nxt.prm.flush_bin = wdata_i;
			end else if (addr_i == csr_pkg::OFS_FLUSH_SAMPLE) begin
				s_nxt.prm.flush_sample = wdata_i;
			end else if (addr_i == csr_pkg::OFS_SAMPLE_CAP) begin
				s_nxt.prm.sample_cap = wdata_i;
			end else if (addr_i == csr_pkg::OFS_SER_CAP) begin
				s_nxt.prm.ser_cap = wdata_i;
			end else if (addr_i == csr_pkg::OFS_OV_ROWS_LO ||
				addr_i == csr_pkg::OFS_OV_COLS_LO ||
				addr_i == csr_pkg::OFS_ERASE_LO ||
				addr_i == csr_pkg::OFS_IDLE_LO ||
				addr_i == csr_pkg::OFS_PRE1_LO ||
				addr_i == csr_pkg::OFS_PRE2_LO) begin
				s_nxt.lo_stage = wdata_i;
			end
		end

		// Readback of held values, one cycle later
		if (rd_i) begin
			if (addr_i == csr_pkg::OFS_MPP) begin
				s_nxt.rdata = {7'h00, s_r.prm.mpp};
			end else if (addr_i == csr_pkg::OFS_OV_ROWS_LO) begin
				s_nxt.rdata = s_r.prm.ov_rows[7:0];
			end else if (addr_i == csr_pkg::OFS_OV_ROWS_HI) begin
				s_nxt.rdata = s_r.prm.ov_rows[15:8];
			end else if (addr_i == csr_pkg::OFS_OV_COLS_LO) begin
				s_nxt.rdata = s_r.prm.ov_cols[7:0];
			end else if (addr_i == csr_pkg::OFS_OV_COLS_HI) begin
				s_nxt.rdata = s_r.prm.ov_cols[15:8];
			end else if (addr_i == csr_pkg::OFS_ERASE_LO) begin
				s_nxt.rdata = s_r.prm.erase_time[7:0];
			end else if (addr_i == csr_pkg::OFS_ERASE_HI) begin
				s_nxt.rdata = s_r.prm.erase_time[15:8];
			end else if (addr_i == csr_pkg::OFS_IDLE_LO) begin
				s_nxt.rdata = s_r.prm.idle_rows[7:0];
			end else if (addr_i == csr_pkg::OFS_IDLE_HI) begin
				s_nxt.rdata = s_r.prm.idle_rows[15:8];
			end else if (addr_i == csr_pkg::OFS_SER_CODE) begin
				s_nxt.rdata = {6'h00, s_r.prm.ser_code};
			end else if (addr_i == csr_pkg::OFS_PRE1_LO) begin
				s_nxt.rdata = s_r.prm.pre1[7:0];
			end else if (addr_i == csr_pkg::OFS_PRE1_HI) begin
				s_nxt.rdata = s_r.prm.pre1[15:8];
			end else if (addr_i == csr_pkg::OFS_PRE2_LO) begin
				s_nxt.rdata = s_r.prm.pre2[7:0];
			end else if (addr_i == csr_pkg::OFS_PRE2_HI) begin
				s_nxt.rdata = s_r.prm.pre2[15:8];
			end else if (addr_i == csr_pkg::OFS_SKIP_FLAG) begin
				s_nxt.rdata = s_r.prm.skip_flag;
			end else if (addr_i == csr_pkg::OFS_SKIP_BIN) begin
				s_nxt.rdata = s_r.prm.skip_bin;
			end else if (addr_i == csr_pkg::OFS_SKIP_SAMPLE) begin
				s_nxt.rdata = s_r.prm.skip_sample;
			end else if (addr_i == csr_pkg::OFS_FLUSH_FLAG) begin
				s_nxt.rdata = s_r.prm.flush_flag;
			end else if (addr_i == csr_pkg::OFS_FLUSH_BIN) begin
				s_nxt.rdata = s_r.prm.flush_bin;
			end else if (addr_i == csr_pkg::OFS_FLUSH_SAMPLE) begin
				s_nxt.rdata = s_r.prm.flush_sample;
			end else if (addr_i == csr_pkg::OFS_SAMPLE_CAP) begin
				s_nxt.rdata = s_r.prm.sample_cap;
			end else if (addr_i == csr_pkg::OFS_SER_CAP) begin
				s_nxt.rdata = s_r.prm.ser_cap;
			end else if (addr_i == csr_pkg::OFS_STATUS) begin
				s_nxt.rdata = {s_r.drv.busy, s_r.row_ov, 2'h0,
					4'(s_r.phase)};
			end else begin
				s_nxt.rdata = 8'h00;
			end
		end

		// Clock modifiers for the current phase
		skip_ph = (s_r.phase == csr_pkg::ST_SKIP1) ||
			(s_r.phase == csr_pkg::ST_SKIP2);
		flush_ph = (s_r.phase == csr_pkg::ST_FSER) &&
			(s_r.fkind != csr_pkg::FK_IDLE);
		bin_cur = window_i.bin_exp;
		smp_cur = window_i.sample;
		if (skip_ph && s_r.prm.skip_flag == 8'h01) begin
			bin_cur = s_r.prm.skip_bin;
			smp_cur = s_r.prm.skip_sample;
		end else if (flush_ph && s_r.prm.flush_flag == 8'h01) begin
			bin_cur = s_r.prm.flush_bin;
			smp_cur = s_r.prm.flush_sample;
		end
		step = bin_step(bin_cur);
		// Waveform step plus the sampling window
		period = ser_cycles(s_r.prm.ser_code) +
			16'(32'(smp_cur) * csr_pkg::SAMPLE_UNIT_CYC);
		px_count = skip_ph || (s_r.phase == csr_pkg::ST_FSER);

		// Derived row geometry
		pre1_avail = (window_i.bin_exp >= 8'h10) ? 32'h0 :
			32'(window_i.col_skip >> window_i.bin_exp[3:0]);
		pre1_eff = (32'(s_r.prm.pre1) > pre1_avail) ?
			pre1_avail[15:0] : s_r.prm.pre1;
		rem = 32'(window_i.row_len) - 32'(window_i.col_skip) -
			(32'(window_i.win_cols) << window_i.bin_exp[4:0]);
		if (rem[31]) begin
			rem = 32'h0;
		end
		pre2_px = 32'(s_r.prm.pre2) << window_i.bin_exp[4:0];

		// Common serial transfer engine
		case (s_r.phase)
			csr_pkg::ST_SKIP1, csr_pkg::ST_PRE1, csr_pkg::ST_PIX,
			csr_pkg::ST_SKIP2, csr_pkg::ST_PRE2, csr_pkg::ST_OVCOL,
			csr_pkg::ST_FSER: begin
				serial = 1'b1;
			end
			default: begin
				serial = 1'b0;
			end
		endcase
		if (serial) begin
			if (s_r.pix == 16'h0000) begin
				done = 1'b1;
			end else if (s_r.tcnt != 16'h0000) begin
				s_nxt.tcnt = s_r.tcnt - 16'h0001;
			end else begin
				s_nxt.drv.ser_tick = 1'b1;
				s_nxt.drv.pix_valid = (s_r.phase == csr_pkg::ST_PIX) ||
					(s_r.phase == csr_pkg::ST_OVCOL);
				s_nxt.tcnt = period - 16'h0001;
				if (px_count) begin
					s_nxt.pix = (s_r.pix > step) ? s_r.pix - step : 16'h0000;
				end else begin
					s_nxt.pix = s_r.pix - 16'h0001;
				end
			end
		end

		leave_idle = 1'b0;
		case (s_r.phase)
			csr_pkg::ST_IDLE: begin
				leave_idle = expose_start_i;
			end
			csr_pkg::ST_FROW, csr_pkg::ST_FSER: begin
				leave_idle = expose_start_i &&
					(s_r.fkind == csr_pkg::FK_IDLE);
			end
			default: begin
				leave_idle = 1'b0;
			end
		endcase

		// Sequence walk
		if (leave_idle) begin
			// No flush transfer may leak into the frozen phases
			s_nxt.drv.ser_tick = 1'b0;
			s_nxt.drv.pix_valid = 1'b0;
			s_nxt.ecnt = 32'h0;
			s_nxt.rows = s_r.prm.erase_time;
			s_nxt.phase = (s_r.prm.erase_time != 16'h0000) ?
				csr_pkg::ST_ERASE : csr_pkg::ST_EXPOSE;
		end else begin
			case (s_r.phase)
				csr_pkg::ST_ERASE: begin
					if (s_r.ecnt == 32'(ERASE_STEP_CYC - 1)) begin
						s_nxt.ecnt = 32'h0;
						s_nxt.rows = s_r.rows - 16'h0001;
						if (s_r.rows == 16'h0001) begin
							s_nxt.phase = csr_pkg::ST_EXPOSE;
						end
					end else begin
						s_nxt.ecnt = s_r.ecnt + 32'h1;
					end
				end
				csr_pkg::ST_EXPOSE: begin
					if (readout_start_i) begin
						s_nxt.fkind = csr_pkg::FK_PSKIP1;
						s_nxt.rows = window_i.par_skip1;
						s_nxt.phase = csr_pkg::ST_FROW;
					end
				end
				csr_pkg::ST_FROW: begin
					if (s_r.rows == 16'h0000) begin
						if (s_r.fkind == csr_pkg::FK_PSKIP1) begin
							s_nxt.phase = csr_pkg::ST_ROWS_INIT;
						end else if (s_r.fkind == csr_pkg::FK_PSKIP2 &&
							s_r.prm.idle_rows != 16'h0000) begin
							s_nxt.fkind = csr_pkg::FK_IDLE;
							s_nxt.rows = s_r.prm.idle_rows;
						end else begin
							s_nxt.phase = csr_pkg::ST_IDLE;
						end
					end else begin
						s_nxt.drv.par_tick = 1'b1;
						s_nxt.pix = window_i.row_len;
						s_nxt.tcnt = 16'h0000;
						s_nxt.phase = csr_pkg::ST_FSER;
					end
				end
				csr_pkg::ST_FSER: begin
					if (done) begin
						// Endless idle never counts down
						if (!(s_r.fkind == csr_pkg::FK_IDLE &&
							s_r.prm.idle_rows == csr_pkg::IDLE_ENDLESS)) begin
							s_nxt.rows = s_r.rows - 16'h0001;
						end
						s_nxt.phase = csr_pkg::ST_FROW;
					end
				end
				csr_pkg::ST_ROWS_INIT: begin
					if (window_i.win_rows != 16'h0000) begin
						s_nxt.row_ov = 1'b0;
						s_nxt.rows = window_i.win_rows;
						s_nxt.phase = csr_pkg::ST_ROWSTART;
					end else if (s_r.prm.ov_rows != 16'h0000) begin
						s_nxt.row_ov = 1'b1;
						s_nxt.rows = s_r.prm.ov_rows;
						s_nxt.phase = csr_pkg::ST_ROWSTART;
					end else begin
						s_nxt.fkind = csr_pkg::FK_PSKIP2;
						s_nxt.rows = window_i.par_skip2;
						s_nxt.phase = csr_pkg::ST_FROW;
					end
				end
				csr_pkg::ST_ROWSTART: begin
					s_nxt.drv.par_tick = !s_r.row_ov;
					s_nxt.pix = window_i.col_skip -
						16'(32'(pre1_eff) << window_i.bin_exp[4:0]);
					s_nxt.tcnt = 16'h0000;
					s_nxt.phase = csr_pkg::ST_SKIP1;
				end
				csr_pkg::ST_SKIP1: begin
					if (done) begin
						s_nxt.pix = pre1_eff;
						s_nxt.phase = csr_pkg::ST_PRE1;
					end
				end
				csr_pkg::ST_PRE1: begin
					if (done) begin
						s_nxt.pix = window_i.win_cols;
						s_nxt.phase = csr_pkg::ST_PIX;
					end
				end
				csr_pkg::ST_PIX: begin
					if (done && s_r.prm.ov_cols != 16'h0000) begin
						s_nxt.pix = (rem > pre2_px) ?
							16'(rem - pre2_px) : 16'h0000;
						s_nxt.phase = csr_pkg::ST_SKIP2;
					end else if (done) begin
						s_nxt.phase = csr_pkg::ST_ROW_END;
					end
				end
				csr_pkg::ST_SKIP2: begin
					if (done) begin
						s_nxt.pix = s_r.prm.pre2;
						s_nxt.phase = csr_pkg::ST_PRE2;
					end
				end
				csr_pkg::ST_PRE2: begin
					if (done) begin
						s_nxt.pix = s_r.prm.ov_cols;
						s_nxt.phase = csr_pkg::ST_OVCOL;
					end
				end
				csr_pkg::ST_OVCOL: begin
					if (done) begin
						s_nxt.phase = csr_pkg::ST_ROW_END;
					end
				end
				csr_pkg::ST_ROW_END: begin
					if (s_r.rows > 16'h0001) begin
						s_nxt.rows = s_r.rows - 16'h0001;
						s_nxt.phase = csr_pkg::ST_ROWSTART;
					end else if (!s_r.row_ov &&
						s_r.prm.ov_rows != 16'h0000) begin
						s_nxt.row_ov = 1'b1;
						s_nxt.rows = s_r.prm.ov_rows;
						s_nxt.phase = csr_pkg::ST_ROWSTART;
					end else begin
						s_nxt.fkind = csr_pkg::FK_PSKIP2;
						s_nxt.rows = window_i.par_skip2;
						s_nxt.phase = csr_pkg::ST_FROW;
					end
				end
				default: begin
					s_nxt.phase = csr_pkg::ST_IDLE;
				end
			endcase
		end

		// Registered drive; the clamp uses the freshly written mpp, the capacitor selectors the already held settings
		s_nxt.drv.special_state = (s_nxt.phase == csr_pkg::ST_ERASE);
		s_nxt.drv.clocks_frozen = (s_nxt.phase == csr_pkg::ST_EXPOSE) ||
			(s_nxt.phase == csr_pkg::ST_IDLE);
		s_nxt.drv.clamp_levels = s_nxt.drv.clocks_frozen &&
			s_nxt.prm.mpp;
		s_nxt.drv.busy = (s_nxt.phase != csr_pkg::ST_IDLE);
		s_nxt.drv.bin_exp = bin_cur;
		s_nxt.drv.sample = smp_cur;
		case (s_r.prm.sample_cap)
			8'h01: s_nxt.drv.sample_cap_large = 1'b1;
			8'h02: s_nxt.drv.sample_cap_large = (bin_cur != 8'h00) ||
				(window_i.sample > csr_pkg::AUTO_CAP_SAMPLE_MAX);
			default: s_nxt.drv.sample_cap_large = 1'b0;
		endcase
		case (s_r.prm.ser_cap)
			8'h01: s_nxt.drv.ser_cap_on = 1'b1;
			8'h02: s_nxt.drv.ser_cap_on = (s_r.prm.ser_code == 2'h0);
			default: s_nxt.drv.ser_cap_on = 1'b0;
		endcase
	end

	// ***********************************************************
	// Registers
	// ***********************************************************
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_r <= '0;
			s_r.prm.pre1 <= csr_pkg::RST_PRE1;
			s_r.prm.pre2 <= csr_pkg::RST_PRE2;
			s_r.prm.ser_code <= csr_pkg::RST_SER_CODE;
			s_r.phase <= csr_pkg::ST_IDLE;
			s_r.fkind <= csr_pkg::FK_PSKIP1;
			s_r.drv.clocks_frozen <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata_o = s_r.rdata;
	assign drive_o = s_r.drv;

endmodule

`default_nettype wire

// ---- testbench/csr_host_model.sv ----
// Host model: writes and reads parameter bytes over the byte port.
// Assumes callers enter each task just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module csr_host (
	input wire logic clock_i,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// Idle cycle after each strobe keeps one change per time step
	task automatic xfer(input bit w, input logic [7:0] a, input logic [7:0] d);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= w;
		rd_o <= !w;
		@(posedge clock_i);
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		wdata_o <= ~d;
		@(posedge clock_i);
	endtask
	task automatic wr16(input logic [7:0] a, input logic [15:0] d);
		xfer(1'b1, a, d[7:0]);
		xfer(1'b1, a + 8'h01, d[15:8]);
	endtask
endmodule
`default_nettype wire

// ---- testbench/csr_monitor.sv ----
// Checker: port timing of the readout sequencer.
// Assumes it is bound to csr_sequencer with the same erase step.
`timescale 1ns/10ps
`default_nettype none
module csr_monitor #(
	parameter int ERASE_STEP_CYC = 10
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire csr_pkg::csr_window_t window_i,
	input wire logic expose_start_i,
	input wire logic readout_start_i,
	input wire csr_pkg::csr_drive_t drive_o
);
	logic mpp_r;
	logic [7:0] lo_r;
	logic [15:0] er_r;
	int cnt_r;
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mpp_r <= 1'b0;
			lo_r <= 8'h00;
			er_r <= 16'h0000;
			cnt_r <= 0;
		end else begin
			cnt_r <= drive_o.special_state ? cnt_r + 1 : 0;
			if (wr_i && addr_i == csr_pkg::OFS_MPP) mpp_r <= wdata_i != 8'h00;
			if (wr_i && addr_i == csr_pkg::OFS_ERASE_LO) lo_r <= wdata_i;
			if (wr_i && addr_i == csr_pkg::OFS_ERASE_HI) er_r <= {wdata_i, lo_r};
		end
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_erase_end; $fell(drive_o.special_state); endsequence
	property p_clamp; $stable(mpp_r) && $stable(drive_o.clocks_frozen) |->
		drive_o.clamp_levels == (drive_o.clocks_frozen && mpp_r); endproperty
	property p_quiet; drive_o.clocks_frozen |->
		!drive_o.par_tick && !drive_o.ser_tick; endproperty
	property p_pix; drive_o.pix_valid |-> drive_o.ser_tick && drive_o.busy;
	endproperty
	property p_erase_len; s_erase_end |-> cnt_r == int'(er_r) * ERASE_STEP_CYC;
	endproperty
	property p_erase_go; $rose(drive_o.special_state) |->
		$past(expose_start_i) || $past(expose_start_i, 2); endproperty
	property p_unmapped; rd_i && addr_i > csr_pkg::OFS_STATUS |=>
		rdata_o == 8'h00; endproperty
	property p_go; expose_start_i && !drive_o.busy |-> ##[1:2] drive_o.busy;
	endproperty
	property p_ro; readout_start_i && drive_o.clocks_frozen && drive_o.busy
		|-> ##[1:2] !drive_o.clocks_frozen; endproperty
	a_clamp: assert property (p_clamp) else $error("clamp level");
	a_quiet: assert property (p_quiet) else $error("ticks frozen");
	a_pix: assert property (p_pix) else $error("pixel outside");
	a_erase_len: assert property (p_erase_len) else $error("erase");
	a_erase_go: assert property (p_erase_go) else $error("erase go");
	a_unmapped: assert property (p_unmapped) else $error("unmapped");
	a_go: assert property (p_go) else $error("start ignored");
	a_ro: assert property (p_ro) else $error("still frozen");
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// Testbench: parameter round trips, exposure and readout walks.
// Assumes host model and checker are compiled before this file.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clock_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] addr_i;
	logic [7:0] wdata_i;
	logic wr_i;
	logic rd_i;
	logic rd_d = 1'b0;
	logic [7:0] rdata_o;
	logic expose_start_i = 1'b0;
	logic readout_start_i = 1'b0;
	csr_pkg::csr_window_t window_i = '{win_rows: 16'h0002,
		win_cols: 16'h0003, row_len: 16'h0003, par_skip1: 16'h0001,
		default: '0};
	csr_pkg::csr_drive_t drive_o;
	logic [7:0] exp_q[$];
	logic [15:0] r16;
	int err_total = 0;
	int samples_checked = 0;
	int cyc = 0;
	int npix = 0;
	int npar = 0;
	logic seen_skip = 1'b0;
	logic seen_flush = 1'b0;
	logic [7:0] mods [6] = '{8'h01, 8'h05, 8'h07, 8'h01, 8'h06, 8'h09};
	int seed = 32'h3b8aa006;
	always #10 clock_i = ~clock_i;
	csr_host csr_host_inst (.clock_i, .addr_o(addr_i), .wdata_o(wdata_i),
		.wr_o(wr_i), .rd_o(rd_i));
	csr_sequencer #(.ERASE_STEP_CYC(10)) csr_sequencer_inst (.clock_i,
		.rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .window_i,
		.expose_start_i, .readout_start_i, .drive_o);
	task automatic cmp(input string n, input logic [15:0] e,
		input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic stop_test;
		if (err_total == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic rd8(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		csr_host_inst.xfer(1'b0, a, 8'h00);
	endtask
	task automatic start(input bit ro);
		if (ro) readout_start_i <= 1'b1;
		else expose_start_i <= 1'b1;
		@(posedge clock_i);
		readout_start_i <= 1'b0;
		expose_start_i <= 1'b0;
	endtask
	always @(posedge clock_i) rd_d <= rd_i;
	// Results are taken mid-cycle, once the edge's updates have landed
	always @(negedge clock_i) begin
		npix += drive_o.pix_valid;
		npar += drive_o.par_tick;
		seen_skip |= drive_o.bin_exp == 8'h05 && drive_o.sample == 8'h07;
		seen_flush |= drive_o.bin_exp == 8'h06 && drive_o.sample == 8'h09;
		cyc++;
		if (rd_d) cmp("rdata", exp_q.pop_front(), rdata_o);
		if (cyc == 20000) begin
			err_total++;
			stop_test();
		end
	end
	initial begin
		repeat (10) @(posedge clock_i);
		rst_b_i <= 1'b1;
		@(posedge clock_i);
		rd8(csr_pkg::OFS_PRE1_LO, 8'h04);
		rd8(csr_pkg::OFS_PRE2_LO, 8'h04);
		rd8(8'h30, 8'h00);
		for (int i = 1; i < 9; i += 2) begin
			r16 = 16'($random(seed));
			csr_host_inst.wr16(8'(i), r16);
			rd8(8'(i), r16[7:0]);
			rd8(8'(i + 1), r16[15:8]);
		end
		for (int j = 0; j < 6; j++) begin
			csr_host_inst.xfer(1'b1, csr_pkg::OFS_SKIP_FLAG + 8'(j), mods[j]);
			rd8(csr_pkg::OFS_SKIP_FLAG + 8'(j), mods[j]);
		end
		csr_host_inst.xfer(1'b1, csr_pkg::OFS_SER_CODE, 8'h03);
		rd8(csr_pkg::OFS_SER_CODE, 8'h03);
		// Both capacitor selectors on auto
		csr_host_inst.xfer(1'b1, csr_pkg::OFS_SAMPLE_CAP, 8'h02);
		csr_host_inst.xfer(1'b1, csr_pkg::OFS_SER_CAP, 8'h02);
		window_i.sample <= 8'h28;
		@(negedge clock_i);
		cmp("scap", 16'h0000, drive_o.sample_cap_large);
		cmp("sercap", 16'h0000, drive_o.ser_cap_on);
		@(negedge clock_i);
		cmp("scap", 16'h0001, drive_o.sample_cap_large);
		@(posedge clock_i);
		window_i.sample <= 8'h27;
		repeat (2) @(negedge clock_i);
		cmp("scap", 16'h0000, drive_o.sample_cap_large);
		@(posedge clock_i);
		window_i.sample <= 8'h00;
		csr_host_inst.xfer(1'b1, csr_pkg::OFS_SER_CODE, 8'h00);
		@(negedge clock_i);
		cmp("sercap", 16'h0001, drive_o.ser_cap_on);
		@(posedge clock_i);
		csr_host_inst.xfer(1'b1, csr_pkg::OFS_SER_CODE, 8'h03);
		csr_host_inst.wr16(csr_pkg::OFS_OV_ROWS_LO, 16'h0001);
		csr_host_inst.wr16(csr_pkg::OFS_OV_COLS_LO, 16'h0002);
		csr_host_inst.wr16(csr_pkg::OFS_ERASE_LO, 16'h0002);
		// Pass one idles frozen, pass two flushes without end
		for (int k = 1; k >= 0; k--) begin
			csr_host_inst.wr16(csr_pkg::OFS_IDLE_LO, k ? 16'h0000 : 16'hFFFF);
			csr_host_inst.xfer(1'b1, csr_pkg::OFS_MPP, 8'(k));
			start(1'b0);
			repeat (25) @(negedge clock_i);
			cmp("clamp", 16'(k), drive_o.clamp_levels);
			npix = 0;
			npar = 0;
			seen_skip = 1'b0;
			seen_flush = 1'b0;
			@(posedge clock_i);
			start(1'b1);
			repeat (2000) @(negedge clock_i);
			cmp("pixels", 16'h000F, 16'(npix));
			cmp("rows", 16'h0001, k ? npar == 3 : npar > 3);
			cmp("frozen", 16'(k), drive_o.clocks_frozen);
			cmp("skipbin", 16'h0001, 16'(seen_skip));
			cmp("flushbin", 16'h0001, 16'(seen_flush));
			@(posedge clock_i);
		end
		start(1'b0);
		repeat (2) @(negedge clock_i);
		cmp("erase", 16'h0001, drive_o.special_state);
		stop_test();
	end
endmodule
bind csr_sequencer csr_monitor #(.ERASE_STEP_CYC(ERASE_STEP_CYC))
	csr_monitor_inst (.clock_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .window_i, .expose_start_i, .readout_start_i, .drive_o);
`default_nettype wire
